// ### pkg/pes_pkg.sv
// Shared constants, field layouts and cause codes of the exception sequencer.
package pes_pkg;

    // Register bus geometry and register offsets.
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_SAVE_ADDR = 8'h00;
    localparam logic [7:0] REG_SAVE_STATUS = 8'h04;
    localparam logic [7:0] REG_MSR = 8'h08;
    localparam logic [7:0] REG_DATA_FAULT = 8'h0c;
    localparam logic [7:0] REG_FP_STATUS = 8'h10;
    localparam logic [7:0] REG_EVT_STATUS = 8'h14;
    localparam logic [7:0] REG_EVT_MASK = 8'h18;
    localparam logic [7:0] REG_CAUSE = 8'h1c;
    localparam logic [7:0] REG_ASYNC_EN = 8'h20;

    // Machine status bit positions.
    localparam int EXT_IRQ_ENABLE = 15;
    localparam int MSR_PR = 14;
    localparam int MSR_ME = 12;
    localparam int MSR_FE = 11;
    localparam logic [31:0] MSR_RESET = 32'h0000_1000;
    localparam logic [31:0] MSR_CLR_ON_TAKE = 32'h0000_c800;

    // Floating-point status layout: sticky flags low, trap enables above.
    localparam int FP_FLAGS = 5;
    localparam int FP_EN_LSB = 8;

    // Synchronous condition indexes, lowest index is handled first.
    localparam int SYNC_COUNT = 7;
    localparam int SC_ISI = 0;
    localparam int SC_PROGRAM = 1;
    localparam int SC_FPUNAV = 2;
    localparam int SC_ALIGN = 3;
    localparam int SC_DSI = 4;
    localparam int SC_SYSCALL = 5;
    localparam int SC_TRACE = 6;

    // Asynchronous source indexes, lowest index wins.
    localparam int ASYNC_COUNT = 5;
    localparam int AS_MCHECK = 0;
    localparam int AS_EXT = 1;
    localparam int AS_SMI = 2;
    localparam int AS_DEC = 3;
    localparam int AS_PERF = 4;
    localparam logic [ASYNC_COUNT-1:0] ASYNC_LEVEL = 5'h06;
    localparam logic [ASYNC_COUNT-1:0] ASYNC_EN_RESET = 5'h1e;

    // Synchronised pin indexes.
    localparam int PIN_COUNT = 5;
    localparam int PIN_HARD = 0;
    localparam int PIN_SOFT = 1;
    localparam int PIN_EXT = 2;
    localparam int PIN_SMI = 3;
    localparam int PIN_BUSERR = 4;

    // Interrupt status bits.
    localparam int EV_W = 5;
    localparam int EV_TAKEN = 0;
    localparam int EV_NESTED = 1;
    localparam int EV_RESET = 2;
    localparam int EV_FPFLAG = 3;
    localparam int EV_RFI = 4;

    typedef enum logic [3:0] {
        CAUSE_NONE, CAUSE_RESET, CAUSE_MCHECK, CAUSE_DSI, CAUSE_ISI, CAUSE_EXT,
        CAUSE_ALIGN, CAUSE_PROGRAM, CAUSE_FPUNAV, CAUSE_DEC, CAUSE_SYSCALL,
        CAUSE_TRACE, CAUSE_PERF, CAUSE_SMI
    } pes_cause_type;

    // Vector offset of each cause.
    function automatic logic [19:0] pes_vec_off(input pes_cause_type c);
        unique case (c)
            CAUSE_RESET: return 20'h00100;
            CAUSE_MCHECK: return 20'h00200;
            CAUSE_DSI: return 20'h00300;
            CAUSE_ISI: return 20'h00400;
            CAUSE_EXT: return 20'h00500;
            CAUSE_ALIGN: return 20'h00600;
            CAUSE_PROGRAM: return 20'h00700;
            CAUSE_FPUNAV: return 20'h00800;
            CAUSE_DEC: return 20'h00900;
            CAUSE_SYSCALL: return 20'h00c00;
            CAUSE_TRACE: return 20'h00d00;
            CAUSE_PERF: return 20'h00f00;
            CAUSE_SMI: return 20'h01400;
            default: return 20'h00000;
        endcase
    endfunction

    // Cause of a synchronous condition index.
    function automatic pes_cause_type pes_sync_cause(input logic [2:0] i);
        unique case (i)
            3'h0: return CAUSE_ISI;
            3'h1: return CAUSE_PROGRAM;
            3'h2: return CAUSE_FPUNAV;
            3'h3: return CAUSE_ALIGN;
            3'h4: return CAUSE_DSI;
            3'h5: return CAUSE_SYSCALL;
            default: return CAUSE_TRACE;
        endcase
    endfunction

    // Cause of an asynchronous source index.
    function automatic pes_cause_type pes_async_cause(input logic [2:0] i);
        unique case (i)
            3'h0: return CAUSE_MCHECK;
            3'h1: return CAUSE_EXT;
            3'h2: return CAUSE_SMI;
            3'h3: return CAUSE_DEC;
            default: return CAUSE_PERF;
        endcase
    endfunction

endpackage

// ### core/pes_sync.sv
// Two-stage synchroniser for pins that arrive from outside the clock domain.
`timescale 1ns/1ns
module pes_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    logic [W-1:0] meta_q;

    if (W < 1) begin : gBadWidth
        $error("pes_sync needs at least one bit");
    end

    // First stage feeds only the second stage.
    for (genvar i = 0; i < W; i++) begin : gBit
        always_ff @(posedge clk) begin
            if (rst) begin
                meta_q[i] <= 1'b0;
                syncOut[i] <= 1'b0;
            end else begin
                meta_q[i] <= asyncIn[i];
                syncOut[i] <= meta_q[i];
            end
        end
    end
endmodule // pes_sync

// ### core/pes_async_arb.sv
// Pending latch and fixed-priority pick for asynchronous exception sources.
`timescale 1ns/1ns
module pes_async_arb
    import pes_pkg::*;
#(
    parameter int N = ASYNC_COUNT,
    parameter logic [N-1:0] LEVEL_MASK = ASYNC_LEVEL
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [N-1:0] eventIn,
    input wire logic [N-1:0] allowIn,
    input wire logic takeIn,
    output logic [N-1:0] pendOut,
    output logic reqValid,
    output logic [$clog2(N)-1:0] reqIdx
);
    localparam int IW = $clog2(N);
    logic [N-1:0] pend_q;

    if (N < 2) begin : gBadCount
        $error("pes_async_arb needs at least two sources");
    end

    // Edge sources latch until taken; a new event beats the clearing take.
    for (genvar i = 0; i < N; i++) begin : gBit
        always_ff @(posedge clk) begin
            if (rst) begin
                pend_q[i] <= 1'b0;
            end else if (LEVEL_MASK[i]) begin
                pend_q[i] <= eventIn[i];
            end else if (eventIn[i]) begin
                pend_q[i] <= 1'b1;
            end else if (takeIn && reqIdx == IW'(i)) begin
                pend_q[i] <= 1'b0;
            end
        end
    end

    // Lowest allowed pending index wins.
    always_comb begin
        reqValid = 1'b0;
        reqIdx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (pend_q[i] && allowIn[i]) begin
                reqValid = 1'b1;
                reqIdx = IW'(i);
            end
        end
    end

    assign pendOut = pend_q;
endmodule // pes_async_arb

// ### core/pes_core.sv
// Precise exception sequencer: recognition, ordering, context save and redirect.
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ns
// How it works
// (RULE1) Taking an exception saves context, enters supervisor state and redirects to its vector.
// (RULE2) Exceptions are handled in instruction-stream order, only at the oldest instruction.
// (RULE3) An instruction's exception is taken only when it retires, so all older ones are done.
// (RULE4) Several conditions of one instruction are taken one at a time, never merged.
// (RULE5) Asynchronous precise events latch at once and wait until execution is empty; EXT and SMI follow their pins and are not latched.
// (RULE6) A new exception may be taken inside a handler and overwrites the save registers.
// (RULE7) Shared vectors leave the specific cause in the data fault and fp status registers.
// (RULE8) Software enable bits stop disabled conditions from being taken.
// (RULE9) IEEE floating-point flags are status; they trap only when enabled and allowed.
// (RULE10) Triggers come from instruction results, pins, bus errors and internal events.
// (RULE11) The save address lets the faulting instruction be executed again after return.
// (RULE12) Hard, soft and power-on reset vector to the system reset offset.
// (RULE13) The external interrupt is taken only with its enable set and the input high.
// (RULE14) Resume address and status go to the two save registers; return restores status.
// (RULE15) Pending asynchronous events are picked by fixed priority, one per boundary.
module pes_core
    import pes_pkg::*;
#(
    parameter logic [31:0] VEC_BASE = 32'h0000_0000
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic hardResetIn,
    input wire logic softResetIn,
    input wire logic extIrqIn,
    input wire logic smIrqIn,
    input wire logic busErrIn,
    input wire logic decEvent,
    input wire logic perfEvent,
    input wire logic execEmpty,
    input wire logic retireValid,
    input wire logic [31:0] retireAddr,
    input wire logic [31:0] retireNextAddr,
    input wire logic [SYNC_COUNT-1:0] retireCond,
    input wire logic [FP_FLAGS-1:0] retireFpFlags,
    input wire logic [31:0] retireFault,
    input wire logic retireRfi,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    output logic redirValid,
    output logic [31:0] redirAddr,
    output logic [31:0] msrOut,
    output logic supervisor,
    output logic irq
);
    localparam int SIW = $clog2(SYNC_COUNT);
    localparam int AIW = $clog2(ASYNC_COUNT);

    if (VEC_BASE[19:0] != 20'h00000) begin : gBadBase
        $error("VEC_BASE must leave the vector offset bits clear");
    end

    logic [PIN_COUNT-1:0] pinSync;
    logic softPrev_q;
    logic busPrev_q;
    logic resetPend_q;
    logic [31:0] saveAddr_q;
    logic [31:0] saveStatus_q;
    logic [31:0] msr_q;
    logic [31:0] dataFault_q;
    logic [FP_FLAGS-1:0] fpFlags_q;
    logic [FP_FLAGS-1:0] fpEn_q;
    logic [EV_W-1:0] evtStat_q;
    logic [EV_W-1:0] evtMask_q;
    logic [EV_W-1:0] evtSet;
    logic [ASYNC_COUNT-1:0] asyncEn_q;
    pes_cause_type cause_q;
    logic inHandler_q;
    logic [31:0] nextPc_q;
    logic [SYNC_COUNT-1:0] left_q;
    logic [31:0] leftAddr_q;
    logic [SYNC_COUNT-1:0] condAll;
    logic [SIW-1:0] syncIdx;
    logic syncHit;
    logic fpTrap;
    logic [ASYNC_COUNT-1:0] asyncEvent;
    logic [ASYNC_COUNT-1:0] asyncAllow;
    logic [ASYNC_COUNT-1:0] asyncPend;
    logic asyncReq;
    logic [AIW-1:0] asyncIdx;
    logic blocked;
    logic takeReset;
    logic takeSync;
    logic takeAsync;
    logic takeAny;
    logic doRfi;
    logic doRetire;
    pes_cause_type takeCause;
    logic [31:0] takeSaveAddr;

    // Pins from outside the clock domain.
    pes_sync #(
        .W(PIN_COUNT)
    ) uSync (
        .clk(clk),
        .rst(rst),
        .asyncIn({busErrIn, smIrqIn, extIrqIn, softResetIn, hardResetIn}),
        .syncOut(pinSync)
    );

    // (RULE10) asynchronous trigger sources
    always_comb begin
        asyncEvent = '0;
        asyncEvent[AS_MCHECK] = pinSync[PIN_BUSERR] && !busPrev_q;
        asyncEvent[AS_EXT] = pinSync[PIN_EXT];
        asyncEvent[AS_SMI] = pinSync[PIN_SMI];
        asyncEvent[AS_DEC] = decEvent;
        asyncEvent[AS_PERF] = perfEvent;
    end

    // (RULE8) software enable gating
    always_comb begin
        asyncAllow = asyncEn_q;
        asyncAllow[AS_MCHECK] = msr_q[MSR_ME];
        // (RULE13) external interrupt enable
        asyncAllow[AS_EXT] = asyncEn_q[AS_EXT] && msr_q[EXT_IRQ_ENABLE];
        asyncAllow[AS_SMI] = asyncEn_q[AS_SMI] && msr_q[EXT_IRQ_ENABLE];
        asyncAllow[AS_DEC] = asyncEn_q[AS_DEC] && msr_q[EXT_IRQ_ENABLE];
        asyncAllow[AS_PERF] = asyncEn_q[AS_PERF] && msr_q[EXT_IRQ_ENABLE];
    end

    // (RULE15) fixed priority among pending events
    pes_async_arb #(
        .N(ASYNC_COUNT),
        .LEVEL_MASK(ASYNC_LEVEL)
    ) uArb (
        .clk(clk),
        .rst(rst),
        .eventIn(asyncEvent),
        .allowIn(asyncAllow),
        .takeIn(takeAsync),
        .pendOut(asyncPend),
        .reqValid(asyncReq),
        .reqIdx(asyncIdx)
    );

    // Edge history for the soft reset and bus error pins.
    always_ff @(posedge clk) begin
        if (rst) begin
            softPrev_q <= 1'b0;
            busPrev_q <= 1'b0;
        end else begin
            softPrev_q <= pinSync[PIN_SOFT];
            busPrev_q <= pinSync[PIN_BUSERR];
        end
    end

    // (RULE9) IEEE flags trap only when enabled and allowed
    assign fpTrap = msr_q[MSR_FE] && |(retireFpFlags & fpEn_q);

    // (RULE4) leftover conditions of the same instruction rejoin on re-execution
    always_comb begin
        condAll = retireCond;
        condAll[SC_PROGRAM] = retireCond[SC_PROGRAM] || fpTrap;
        if (leftAddr_q == retireAddr) begin
            condAll = condAll | left_q;
        end
    end

    // (RULE2) lowest condition index is taken first
    always_comb begin
        syncHit = 1'b0;
        syncIdx = '0;
        for (int i = SYNC_COUNT - 1; i >= 0; i--) begin
            if (condAll[i]) begin
                syncHit = 1'b1;
                syncIdx = SIW'(i);
            end
        end
    end

    // One decision per cycle; the cycle after a redirect the pipeline is flushing.
    assign blocked = redirValid;
    // (RULE12) reset vectoring has top priority
    assign takeReset = resetPend_q && !pinSync[PIN_HARD] && !blocked;
    // (RULE3) exception taken only at retirement of the oldest instruction
    assign takeSync = !takeReset && !blocked && retireValid && syncHit;
    assign doRfi = !takeReset && !blocked && retireValid && !syncHit && retireRfi;
    assign doRetire = !takeReset && !blocked && retireValid && !syncHit;
    // (RULE5) asynchronous events wait for an empty execute stage
    assign takeAsync = !takeReset && !blocked && !retireValid && execEmpty && asyncReq;
    assign takeAny = takeReset || takeSync || takeAsync;

    // Cause and resume address of the exception being taken.
    always_comb begin
        takeCause = CAUSE_NONE;
        takeSaveAddr = nextPc_q;
        if (takeReset) begin
            takeCause = CAUSE_RESET;
        end else if (takeSync) begin
            takeCause = pes_sync_cause(3'(syncIdx));
            // (RULE11) faulting instruction is resumed, calls and traces move on
            if (syncIdx == SIW'(SC_SYSCALL) || syncIdx == SIW'(SC_TRACE)) begin
                takeSaveAddr = retireNextAddr;
            end else begin
                takeSaveAddr = retireAddr;
            end
        end else if (takeAsync) begin
            takeCause = pes_async_cause(3'(asyncIdx));
        end
    end

    // (RULE12) reset pending after any reset source
    always_ff @(posedge clk) begin
        if (rst) begin
            resetPend_q <= 1'b1;
        end else if (pinSync[PIN_HARD] || (pinSync[PIN_SOFT] && !softPrev_q)) begin
            resetPend_q <= 1'b1;
        end else if (takeReset) begin
            resetPend_q <= 1'b0;
        end
    end

    // (RULE4) remember untaken conditions of the faulting instruction
    always_ff @(posedge clk) begin
        if (rst) begin
            left_q <= '0;
            leftAddr_q <= 32'h0000_0000;
        end else if (takeSync) begin
            left_q <= condAll & ~(SYNC_COUNT'(1) << syncIdx);
            leftAddr_q <= retireAddr;
        end else if (doRetire && leftAddr_q == retireAddr) begin
            left_q <= '0;
        end
    end

    // (RULE1) redirect fetch to the vector or the return address
    always_ff @(posedge clk) begin
        if (rst) begin
            redirValid <= 1'b0;
            redirAddr <= 32'h0000_0000;
        end else begin
            redirValid <= takeAny || doRfi;
            if (takeAny) begin
                redirAddr <= VEC_BASE | {12'h000, pes_vec_off(takeCause)};
            end else if (doRfi) begin
                redirAddr <= saveAddr_q;
            end
        end
    end

    // Address of the next instruction in program order.
    always_ff @(posedge clk) begin
        if (rst) begin
            nextPc_q <= 32'h0000_0000;
        end else if (takeAny) begin
            nextPc_q <= VEC_BASE | {12'h000, pes_vec_off(takeCause)};
        end else if (doRfi) begin
            nextPc_q <= saveAddr_q;
        end else if (doRetire) begin
            nextPc_q <= retireNextAddr;
        end
    end

    // (RULE14) save resume address and status; (RULE6) nesting overwrites them
    always_ff @(posedge clk) begin
        if (rst) begin
            saveAddr_q <= 32'h0000_0000;
            saveStatus_q <= 32'h0000_0000;
        end else if (takeAny) begin
            saveAddr_q <= takeSaveAddr;
            saveStatus_q <= msr_q;
        end else if (regWr && regAddr == REG_SAVE_ADDR) begin
            saveAddr_q <= regWrData;
        end else if (regWr && regAddr == REG_SAVE_STATUS) begin
            saveStatus_q <= regWrData;
        end
    end

    // (RULE1) supervisor state on take; (RULE14) status restored on return
    always_ff @(posedge clk) begin
        if (rst) begin
            msr_q <= MSR_RESET;
        end else if (takeReset) begin
            msr_q <= MSR_RESET;
        end else if (takeAny) begin
            msr_q <= msr_q & ~MSR_CLR_ON_TAKE;
        end else if (doRfi) begin
            msr_q <= saveStatus_q;
        end else if (regWr && regAddr == REG_MSR) begin
            msr_q <= regWrData;
        end
    end

    // (RULE6) handler nesting tracker
    always_ff @(posedge clk) begin
        if (rst) begin
            inHandler_q <= 1'b0;
        end else if (takeAny) begin
            inHandler_q <= 1'b1;
        end else if (doRfi) begin
            inHandler_q <= 1'b0;
        end
    end

    // (RULE7) specific cause for shared vectors
    always_ff @(posedge clk) begin
        if (rst) begin
            cause_q <= CAUSE_NONE;
            dataFault_q <= 32'h0000_0000;
        end else if (takeAny) begin
            cause_q <= takeCause;
            if (takeSync && syncIdx == SIW'(SC_DSI)) begin
                dataFault_q <= retireFault;
            end
        end
    end

    // (RULE9) sticky IEEE flags, new flags win over a software write
    always_ff @(posedge clk) begin
        if (rst) begin
            fpFlags_q <= '0;
            fpEn_q <= '0;
        end else begin
            if (regWr && regAddr == REG_FP_STATUS) begin
                fpFlags_q <= regWrData[FP_FLAGS-1:0] | (retireValid ? retireFpFlags : '0);
                fpEn_q <= regWrData[FP_EN_LSB +: FP_FLAGS];
            end else if (retireValid && !blocked) begin
                fpFlags_q <= fpFlags_q | retireFpFlags;
            end
        end
    end

    // (RULE8) software enables of the maskable sources
    always_ff @(posedge clk) begin
        if (rst) begin
            asyncEn_q <= ASYNC_EN_RESET;
            evtMask_q <= '0;
        end else begin
            if (regWr && regAddr == REG_ASYNC_EN) begin
                asyncEn_q <= regWrData[ASYNC_COUNT-1:0];
            end
            if (regWr && regAddr == REG_EVT_MASK) begin
                evtMask_q <= regWrData[EV_W-1:0];
            end
        end
    end

    // Events reported to software.
    always_comb begin
        evtSet = '0;
        evtSet[EV_TAKEN] = takeAny;
        evtSet[EV_NESTED] = takeAny && inHandler_q;
        evtSet[EV_RESET] = takeReset;
        evtSet[EV_FPFLAG] = retireValid && !blocked && |(retireFpFlags & ~fpFlags_q);
        evtSet[EV_RFI] = doRfi;
    end

    // Sticky status, write one to clear, a new event wins over the clear.
    always_ff @(posedge clk) begin
        if (rst) begin
            evtStat_q <= '0;
        end else if (regWr && regAddr == REG_EVT_STATUS) begin
            evtStat_q <= (evtStat_q & ~regWrData[EV_W-1:0]) | evtSet;
        end else begin
            evtStat_q <= evtStat_q | evtSet;
        end
    end

    // Registered read data, zero for unmapped offsets and idle cycles.
    always_ff @(posedge clk) begin
        if (rst) begin
            regRdData <= 32'h0000_0000;
        end else if (regRd) begin
            unique case (regAddr)
                REG_SAVE_ADDR: regRdData <= saveAddr_q;
                REG_SAVE_STATUS: regRdData <= saveStatus_q;
                REG_MSR: regRdData <= msr_q;
                REG_DATA_FAULT: regRdData <= dataFault_q;
                REG_FP_STATUS: regRdData <= {19'h0, fpEn_q, 3'h0, fpFlags_q};
                REG_EVT_STATUS: regRdData <= {27'h0, evtStat_q};
                REG_EVT_MASK: regRdData <= {27'h0, evtMask_q};
                REG_CAUSE: regRdData <= {inHandler_q, 3'h0, 11'h0, asyncPend,
                                         7'h0, left_q != '0, cause_q};
                REG_ASYNC_EN: regRdData <= {27'h0, asyncEn_q};
                default: regRdData <= 32'h0000_0000;
            endcase
        end else begin
            regRdData <= 32'h0000_0000;
        end
    end

    assign msrOut = msr_q;
    assign supervisor = !msr_q[MSR_PR];
    assign irq = |(evtStat_q & evtMask_q);
endmodule // pes_core

// ### dv/pes_pipe_model.sv
// Behavioural model of the pipeline that retires instructions into the sequencer.
`timescale 1ns/1ns
module pes_pipe_model
    import pes_pkg::*;
(
    input wire logic clk,
    output logic retireValid,
    output logic [31:0] retireAddr,
    output logic [31:0] retireNextAddr,
    output logic [SYNC_COUNT-1:0] retireCond,
    output logic [FP_FLAGS-1:0] retireFpFlags,
    output logic [31:0] retireFault,
    output logic retireRfi,
    output logic execEmpty,
    output logic decEvent
);
    // The pipeline starts drained and quiet.
    initial begin
        retireValid = 1'b0;
        retireAddr = 32'h0;
        retireNextAddr = 32'h0;
        retireCond = '0;
        retireFpFlags = '0;
        retireFault = 32'h0;
        retireRfi = 1'b0;
        execEmpty = 1'b1;
        decEvent = 1'b0;
    end

    // One instruction offered for one cycle; released address shows inverse.
    task automatic retire(input logic [31:0] a, input logic [SYNC_COUNT-1:0] c,
                          input logic r);
        @(posedge clk);
        retireValid <= 1'b1;
        retireAddr <= a;
        retireNextAddr <= a + 32'h4;
        retireCond <= c;
        retireFault <= a ^ 32'h5a5a_0000;
        retireRfi <= r;
        @(posedge clk);
        retireValid <= 1'b0;
        retireAddr <= ~a;
        retireCond <= '0;
        retireRfi <= 1'b0;
    endtask

    // A one-cycle decrementer event.
    task automatic pulseDec();
        @(posedge clk);
        decEvent <= 1'b1;
        @(posedge clk);
        decEvent <= 1'b0;
    endtask
endmodule // pes_pipe_model

// ### dv/pes_core_sva.sv
// Concurrent checks on the ports of the exception sequencer.
`timescale 1ns/1ns
module pes_core_sva
    import pes_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic extIrqIn,
    input wire logic retireValid,
    input wire logic [SYNC_COUNT-1:0] retireCond,
    input wire logic retireRfi,
    input wire logic regRd,
    input wire logic [31:0] regRdData,
    input wire logic redirValid,
    input wire logic [31:0] redirAddr,
    input wire logic [31:0] msrOut,
    input wire logic supervisor
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Accepted retires that carry a condition or a return.
    sequence s_exc;
        retireValid && !redirValid && retireCond != '0;
    endsequence
    sequence s_rfi;
        retireValid && !redirValid && retireRfi;
    endsequence
    AST_SUPV: assert property (supervisor == !msrOut[MSR_PR])
        else $error("supervisor flag disagrees with status");
    AST_VEC: assert property (redirValid && !$past(retireValid && retireRfi) |-> redirAddr[7:0] == 8'h00)
        else $error("redirect not on a vector");
    AST_EXC: assert property (s_exc |=> redirValid && !msrOut[EXT_IRQ_ENABLE])
        else $error("condition not taken");
    AST_ISI: assert property (s_exc ##0 retireCond[SC_ISI] |=> redirAddr == 32'h400)
        else $error("lowest condition not first");
    AST_RFI: assert property (s_rfi |=> redirValid)
        else $error("return did not redirect");
    AST_RESET: assert property ($fell(rst) |-> ##[1:3] redirAddr == 32'h100)
        else $error("reset vector missing");
    AST_EXT: assert property (redirValid && redirAddr == 32'h500 |->
        $past(msrOut[EXT_IRQ_ENABLE]) && $past(extIrqIn, 4))
        else $error("external take without enable");
    AST_RD: assert property (!$past(regRd) |-> regRdData == 32'h0)
        else $error("read data outside its cycle");
endmodule // pes_core_sva

bind pes_core pes_core_sva u_sva (.clk, .rst, .extIrqIn, .retireValid, .retireCond,
    .retireRfi, .regRd, .regRdData, .redirValid, .redirAddr, .msrOut, .supervisor);

// ### dv/tb.sv
// Self-checking testbench of the exception sequencer.
`timescale 1ns/1ns
module tb
    import pes_pkg::*;
;
    logic clk, rst, regWr, regRd, extIrqIn, softRst, redirValid, supervisor, irq;
    logic [7:0] regAddr;
    logic [31:0] regWrData, regRdData, redirAddr, msrOut;
    wire logic retireValid, retireRfi, execEmpty, decEvent;
    wire logic [31:0] retireAddr, retireNextAddr, retireFault;
    wire logic [SYNC_COUNT-1:0] retireCond;
    wire logic [FP_FLAGS-1:0] retireFpFlags;
    int error_cnt = 0, n_tests = 0, cyc = 0;

    pes_core uut (.clk, .rst, .hardResetIn(1'b0), .softResetIn(softRst), .extIrqIn,
        .smIrqIn(1'b0), .busErrIn(1'b0), .decEvent, .perfEvent(1'b0), .execEmpty,
        .retireValid, .retireAddr, .retireNextAddr, .retireCond, .retireFpFlags,
        .retireFault, .retireRfi, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
        .redirValid, .redirAddr, .msrOut, .supervisor, .irq);
    pes_pipe_model pm (.clk, .retireValid, .retireAddr, .retireNextAddr, .retireCond,
        .retireFpFlags, .retireFault, .retireRfi, .execEmpty, .decEvent);

    // Free-running core clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic summarize();
        $display("tests %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 chk(regRdData, e);
    endtask
    task automatic redir(input logic [31:0] e);
        int i;
        #1;
        for (i = 0; i < 20 && redirValid !== 1'b1; i++) @(posedge clk) #1;
        chk({31'h0, redirValid}, 32'h1);
        chk(redirAddr, e);
    endtask

    task automatic quiet(input int n);
        repeat (n) begin
            @(posedge clk) #1;
            chk({31'h0, redirValid}, 32'h0);
        end
    endtask

    task automatic tSync();
        pm.retire(32'h2000, 7'h11, 1'b0);
        redir(32'h400);
        rd(REG_SAVE_ADDR, 32'h2000);
        rd(REG_SAVE_STATUS, MSR_RESET);
        wr(REG_SAVE_ADDR, 32'h7777);
        pm.retire(32'h2000, 7'h00, 1'b0);
        redir(32'h300);
        rd(REG_SAVE_ADDR, 32'h2000);
        rd(REG_DATA_FAULT, 32'h5a5a_2000);
    endtask

    task automatic tRfi();
        wr(REG_SAVE_ADDR, 32'h3000);
        wr(REG_SAVE_STATUS, 32'h9000);
        pm.retire(32'h2100, 7'h00, 1'b1);
        redir(32'h3000);
        rd(REG_MSR, 32'h9000);
    endtask

    task automatic tAsync();
        @(posedge clk);
        pm.execEmpty <= 1'b0;
        extIrqIn <= 1'b1;
        pm.pulseDec();
        quiet(6);
        @(posedge clk);
        pm.execEmpty <= 1'b1;
        redir(32'h500);
        @(posedge clk);
        extIrqIn <= 1'b0;
        quiet(4);
        wr(REG_MSR, 32'h9000);
        redir(32'h900);
        @(posedge clk);
        extIrqIn <= 1'b1;
        quiet(6);
        @(posedge clk);
        extIrqIn <= 1'b0;
        softRst <= 1'b1;
        redir(32'h100);
    endtask

    task automatic tIrq();
        wr(REG_EVT_MASK, 32'h1);
        @(posedge clk) #1 chk({31'h0, irq}, 32'h1);
        wr(REG_EVT_STATUS, 32'h1f);
        @(posedge clk) #1 chk({31'h0, irq}, 32'h0);
        rd(8'hfc, 32'h0);
    endtask

    // Reset, then the scenarios one after another.
    initial begin
        rst = 1'b1;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 8'h00;
        regWrData = 32'h0;
        extIrqIn = 1'b0;
        softRst = 1'b0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        redir(32'h100);
        rd(REG_MSR, MSR_RESET);
        tSync();
        tRfi();
        tAsync();
        tIrq();
        summarize();
    end

    // Cuts a hung run short.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            summarize();
        end
    end
endmodule // tb
